//--- pkg/fels_defines.svh
// Command codes, status bit positions and host register offsets
`ifndef FELS_DEFINES_SVH
`define FELS_DEFINES_SVH
`define FELS_CMD_ERASE_SETUP 8'h20
`define FELS_CMD_CONFIRM 8'hD0
`define FELS_CMD_READ_STATUS 8'h70
`define FELS_CMD_SUSPEND 8'hB0
`define FELS_CMD_LOCK_SETUP 8'h60
`define FELS_CMD_LOCK 8'h01
`define FELS_CMD_LOCKDOWN 8'h2F
`define FELS_CMD_READ_ID 8'h90
`define FELS_CMD_READ_ARRAY 8'hFF
`define FELS_CMD_OTP_SETUP 8'hC0
`define FELS_CMD_PROG_SETUP 8'h40
`define FELS_CMD_CLEAR_STATUS 8'h50
`define FELS_SR_READY 7
`define FELS_SR_SUSP 6
`define FELS_SR_ERASE_FAIL 5
`define FELS_SR_PROG_FAIL 4
`define FELS_SR_SUPPLY 3
`define FELS_SR_LOCKED 1
`define FELS_ID_LOCK_OFS 16'h0002
`define FELS_HIDDEN_DATA 16'hFFFF
`define FELS_OTP_BASE 16'h0080
`define FELS_REG_ADDR 4'h0
`define FELS_REG_WDATA 4'h4
`define FELS_REG_READ 4'h8
`define FELS_REG_RDATA 4'hC
`endif

//--- pkg/fels_pkg.sv
// Types shared by both ends of the flash command link
`default_nettype none
package fels_pkg;
   typedef enum {FELS_W_READY, FELS_W_ERASE, FELS_W_PROG, FELS_W_SUSP} fels_wsm_e;
   typedef enum {FELS_P_NONE, FELS_P_ERASE, FELS_P_LOCK, FELS_P_OTP, FELS_P_PROG} fels_pend_e;
   typedef enum {FELS_M_ARRAY, FELS_M_STATUS, FELS_M_ID} fels_mode_e;
   typedef enum logic [1:0] {FELS_OP_ERASE = 2'h0, FELS_OP_PROG = 2'h1, FELS_OP_OTP = 2'h2} fels_op_e;
   typedef enum {FELS_H_IDLE, FELS_H_LINK, FELS_H_WAIT, FELS_H_ACK} fels_host_e;
endpackage
`default_nettype wire

//--- pkg/fels_if.sv
// Flash bus between host controller and flash device
`default_nettype none
interface fels_if #(parameter int ADDR_W = 16, parameter int DATA_W = 16) (input wire logic clock,
   input wire logic rst);
   logic wr_en;
   logic rd_en;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;
   logic rvalid;
   modport host (input clock, rst, rdata, rvalid, output wr_en, rd_en, addr, wdata);
   modport device (input clock, rst, wr_en, rd_en, addr, wdata, output rdata, rvalid);
endinterface
`default_nettype wire

//--- src/fels_device.sv
// Flash command interpreter and write state machine
//
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`include "fels_defines.svh"
`default_nettype none
module fels_device
   import fels_pkg::*;
#(
   parameter int ADDR_W = 16,
   parameter int DATA_W = 16,
   parameter int BLOCK_SHIFT = 12,
   parameter int PART_SHIFT = 14,
   parameter int OTP_WORDS = 16,
   parameter int ERASE_CYCLES = 64,
   parameter int PROG_CYCLES = 8
) (
   fels_if.device bus,
   input wire logic program_supply_pin,
   input wire logic array_fail,
   input wire logic otp_locked,
   input wire logic [DATA_W-1:0] array_rdata,
   output logic op_start,
   output logic [1:0] op_kind,
   output logic [ADDR_W-1:0] op_addr,
   output logic [DATA_W-1:0] op_data,
   output logic [7:0] operation_status
);
   localparam int NBLK = 1 << (ADDR_W - BLOCK_SHIFT);
   localparam int NPART = 1 << (ADDR_W - PART_SHIFT);
   localparam int BW = ADDR_W - BLOCK_SHIFT;
   localparam int PW = ADDR_W - PART_SHIFT;

   function automatic logic [BW-1:0] blk_of(input logic [ADDR_W-1:0] a);
      blk_of = a[ADDR_W-1:BLOCK_SHIFT];
   endfunction

   function automatic logic [PW-1:0] part_of(input logic [ADDR_W-1:0] a);
      part_of = a[ADDR_W-1:PART_SHIFT];
   endfunction

   // ======================================================
   // Command decode
   fels_wsm_e wsm;
   fels_pend_e pend;
   fels_mode_e mode [NPART];
   logic [ADDR_W-1:0] pend_addr;
   logic [BW-1:0] erase_blk;
   logic [15:0] count;
   logic [15:0] prog_count;
   logic [NBLK-1:0] locked;
   logic [NBLK-1:0] down;
   logic [7:0] code;
   logic [BW-1:0] wblk;
   logic [PW-1:0] wpart;
   logic same_blk;
   logic otp_in_range;
   logic done;
   logic [7:0] err_set;
   logic clr;
   logic start_erase;
   logic start_prog;
   logic start_otp;
   logic lock_ok;

   assign code = bus.wdata[7:0];
   assign wblk = blk_of(bus.addr);
   assign wpart = part_of(bus.addr);
   assign same_blk = wblk == blk_of(pend_addr);
   assign otp_in_range = bus.addr >= `FELS_OTP_BASE && bus.addr < `FELS_OTP_BASE + ADDR_W'(OTP_WORDS);
   assign done = (wsm == FELS_W_ERASE && count == 16'h0000) || (wsm == FELS_W_PROG && prog_count == 16'h0000);
   assign clr = bus.wr_en && pend == FELS_P_NONE && code == `FELS_CMD_CLEAR_STATUS;

   // Outcome of a confirm or data cycle
   always_comb begin
      err_set = 8'h00;
      start_erase = 1'b0;
      start_prog = 1'b0;
      start_otp = 1'b0;
      lock_ok = 1'b0;
      if (bus.wr_en) begin
         unique case (pend)
            FELS_P_ERASE: begin
               if (code != `FELS_CMD_CONFIRM || !same_blk) begin
                  err_set[`FELS_SR_ERASE_FAIL] = 1'b1;
                  err_set[`FELS_SR_PROG_FAIL] = 1'b1;
               end else if (!program_supply_pin) begin
                  err_set[`FELS_SR_SUPPLY] = 1'b1;
               end else if (locked[wblk]) begin
                  err_set[`FELS_SR_LOCKED] = 1'b1;
               end else begin
                  start_erase = 1'b1;
               end
            end
            FELS_P_LOCK: begin
               if (!same_blk || (code != `FELS_CMD_LOCK && code != `FELS_CMD_CONFIRM &&
                     code != `FELS_CMD_LOCKDOWN)) begin
                  err_set[`FELS_SR_ERASE_FAIL] = 1'b1;
                  err_set[`FELS_SR_PROG_FAIL] = 1'b1;
               end else begin
                  lock_ok = 1'b1;
               end
            end
            FELS_P_OTP: begin
               if (!otp_in_range) begin
                  err_set[`FELS_SR_PROG_FAIL] = 1'b1;
               end else if (!program_supply_pin) begin
                  err_set[`FELS_SR_SUPPLY] = 1'b1;
               end else if (otp_locked) begin
                  err_set[`FELS_SR_LOCKED] = 1'b1;
               end else begin
                  start_otp = 1'b1;
               end
            end
            FELS_P_PROG: begin
               if (wsm == FELS_W_SUSP && wblk == erase_blk) begin
                  err_set[`FELS_SR_PROG_FAIL] = 1'b1;
               end else if (!program_supply_pin) begin
                  err_set[`FELS_SR_SUPPLY] = 1'b1;
               end else if (locked[wblk]) begin
                  err_set[`FELS_SR_LOCKED] = 1'b1;
               end else begin
                  start_prog = 1'b1;
               end
            end
            FELS_P_NONE: begin
            end
         endcase
      end
      if (done && array_fail) begin
         if (wsm == FELS_W_ERASE) begin
            err_set[`FELS_SR_ERASE_FAIL] = 1'b1;
         end else begin
            err_set[`FELS_SR_PROG_FAIL] = 1'b1;
         end
      end
   end

   // ======================================================
   // Pending setup cycle
   always_ff @(posedge bus.clock or posedge bus.rst) begin
      if (bus.rst) begin
         pend <= FELS_P_NONE;
         pend_addr <= '0;
      end else if (bus.wr_en) begin
         pend <= FELS_P_NONE;
         pend_addr <= bus.addr;
         if (pend == FELS_P_NONE) begin
            if (wsm == FELS_W_READY && code == `FELS_CMD_ERASE_SETUP) begin
               pend <= FELS_P_ERASE;
            end else if (wsm == FELS_W_READY && code == `FELS_CMD_LOCK_SETUP) begin
               pend <= FELS_P_LOCK;
            end else if (wsm == FELS_W_READY && code == `FELS_CMD_OTP_SETUP) begin
               pend <= FELS_P_OTP;
            end else if ((wsm == FELS_W_READY || wsm == FELS_W_SUSP) && code == `FELS_CMD_PROG_SETUP) begin
               pend <= FELS_P_PROG;
            end
         end
      end
   end

   // ======================================================
   // Write state machine
   always_ff @(posedge bus.clock or posedge bus.rst) begin
      if (bus.rst) begin
         wsm <= FELS_W_READY;
         count <= 16'h0000;
         erase_blk <= '0;
      end else if (done) begin
         wsm <= (wsm == FELS_W_PROG && operation_status[`FELS_SR_SUSP]) ? FELS_W_SUSP : FELS_W_READY;
      end else if (start_erase) begin
         wsm <= FELS_W_ERASE;
         count <= 16'(ERASE_CYCLES - 1);
         erase_blk <= wblk;
      end else if (start_prog || start_otp) begin
         wsm <= FELS_W_PROG;
      end else if (bus.wr_en && wsm == FELS_W_ERASE && code == `FELS_CMD_SUSPEND &&
            mode[wpart] == FELS_M_STATUS) begin
         wsm <= FELS_W_SUSP;
      end else if (bus.wr_en && wsm == FELS_W_SUSP && pend == FELS_P_NONE && code == `FELS_CMD_CONFIRM) begin
         wsm <= FELS_W_ERASE;
      end else if (wsm == FELS_W_ERASE) begin
         count <= count - 16'h0001;
      end
   end

   // ======================================================
   // Program timer, apart so a suspended erase keeps its time
   always_ff @(posedge bus.clock or posedge bus.rst) begin
      if (bus.rst) begin
         prog_count <= 16'h0000;
      end else if (start_prog || start_otp) begin
         prog_count <= 16'(PROG_CYCLES - 1);
      end else if (wsm == FELS_W_PROG && prog_count != 16'h0000) begin
         prog_count <= prog_count - 16'h0001;
      end
   end

   // ======================================================
   // Status register
   always_ff @(posedge bus.clock or posedge bus.rst) begin
      if (bus.rst) begin
         operation_status <= 8'h80;
      end else begin
         operation_status[`FELS_SR_READY] <= !(start_erase || start_prog || start_otp) &&
            (done || (wsm != FELS_W_ERASE && wsm != FELS_W_PROG));
         if (bus.wr_en && wsm == FELS_W_ERASE && code == `FELS_CMD_SUSPEND && mode[wpart] == FELS_M_STATUS) begin
            operation_status[`FELS_SR_SUSP] <= !done;
         end else if (bus.wr_en && wsm == FELS_W_SUSP && pend == FELS_P_NONE && code == `FELS_CMD_CONFIRM) begin
            operation_status[`FELS_SR_SUSP] <= 1'b0;
         end else if (done && wsm == FELS_W_ERASE) begin
            operation_status[`FELS_SR_SUSP] <= 1'b0;
         end
         // Set wins over clear
         operation_status[5:0] <= (operation_status[5:0] & ~{6{clr}}) | err_set[5:0];
      end
   end

   // ======================================================
   // Block lock bits
   always_ff @(posedge bus.clock or posedge bus.rst) begin
      if (bus.rst) begin
         locked <= '1;
         down <= '0;
      end else if (lock_ok) begin
         if (code == `FELS_CMD_LOCK) begin
            locked[wblk] <= 1'b1;
         end else if (code == `FELS_CMD_LOCKDOWN) begin
            locked[wblk] <= 1'b1;
            down[wblk] <= 1'b1;
         end else if (!down[wblk]) begin
            locked[wblk] <= 1'b0;
         end
      end
   end

   // ======================================================
   // Partition read modes
   always_ff @(posedge bus.clock or posedge bus.rst) begin
      if (bus.rst) begin
         for (int i = 0; i < NPART; i++) begin
            mode[i] <= FELS_M_ARRAY;
         end
      end else if (bus.wr_en) begin
         if (pend != FELS_P_NONE) begin
            mode[wpart] <= FELS_M_STATUS;
         end else if (code == `FELS_CMD_READ_STATUS) begin
            mode[wpart] <= FELS_M_STATUS;
         end else if (code == `FELS_CMD_READ_ARRAY) begin
            mode[wpart] <= FELS_M_ARRAY;
         end else if (code == `FELS_CMD_READ_ID) begin
            mode[wpart] <= FELS_M_ID;
         end else if (code == `FELS_CMD_SUSPEND && wsm == FELS_W_ERASE) begin
            mode[wpart] <= FELS_M_STATUS;
         end
      end
   end

   // ======================================================
   // Read answers
   always_ff @(posedge bus.clock or posedge bus.rst) begin
      if (bus.rst) begin
         bus.rvalid <= 1'b0;
         bus.rdata <= '0;
      end else begin
         bus.rvalid <= bus.rd_en;
         if (bus.rd_en) begin
            unique case (mode[part_of(bus.addr)])
               FELS_M_STATUS: bus.rdata <= DATA_W'(operation_status);
               FELS_M_ID: bus.rdata <= (bus.addr[BLOCK_SHIFT-1:0] == BLOCK_SHIFT'(`FELS_ID_LOCK_OFS)) ?
                  DATA_W'({down[blk_of(bus.addr)], locked[blk_of(bus.addr)]}) : '0;
               FELS_M_ARRAY: bus.rdata <= (wsm == FELS_W_SUSP && blk_of(bus.addr) == erase_blk) ?
                  `FELS_HIDDEN_DATA : array_rdata;
            endcase
         end
      end
   end

   // ======================================================
   // Array operation strobes
   always_ff @(posedge bus.clock or posedge bus.rst) begin
      if (bus.rst) begin
         op_start <= 1'b0;
         op_kind <= 2'h0;
         op_addr <= '0;
         op_data <= '0;
      end else begin
         op_start <= start_erase || start_prog || start_otp;
         if (start_erase || start_prog || start_otp) begin
            op_kind <= start_erase ? FELS_OP_ERASE : (start_otp ? FELS_OP_OTP : FELS_OP_PROG);
            op_addr <= bus.addr;
            op_data <= bus.wdata;
         end
      end
   end
endmodule
`default_nettype wire

//--- src/fels_host.sv
// Host controller: Avalon-MM registers driving flash bus cycles
`include "fels_defines.svh"
`default_nettype none
module fels_host
   import fels_pkg::*;
#(
   parameter int ADDR_W = 16,
   parameter int DATA_W = 16
) (
   fels_if.host bus,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   fels_host_e state;
   logic [ADDR_W-1:0] flash_addr;
   logic [DATA_W-1:0] last_rdata;
   logic link_op;

   // Writes to WDATA or READ start a flash bus cycle
   assign link_op = avs_write && (avs_address == `FELS_REG_WDATA || avs_address == `FELS_REG_READ);

   // ======================================================
   // Sequencer
   always_ff @(posedge bus.clock or posedge bus.rst) begin
      if (bus.rst) begin
         state <= FELS_H_IDLE;
         avs_waitrequest <= 1'b1;
         bus.wr_en <= 1'b0;
         bus.rd_en <= 1'b0;
         bus.addr <= '0;
         bus.wdata <= '0;
      end else begin
         bus.wr_en <= 1'b0;
         bus.rd_en <= 1'b0;
         avs_waitrequest <= 1'b1;
         unique case (state)
            FELS_H_IDLE: begin
               if (link_op) begin
                  state <= FELS_H_LINK;
                  bus.addr <= flash_addr;
                  bus.wdata <= avs_writedata[DATA_W-1:0];
                  bus.wr_en <= avs_address == `FELS_REG_WDATA;
                  bus.rd_en <= avs_address == `FELS_REG_READ;
               end else if (avs_read || avs_write) begin
                  state <= FELS_H_ACK;
                  avs_waitrequest <= 1'b0;
               end
            end
            FELS_H_LINK: begin
               state <= bus.rd_en ? FELS_H_WAIT : FELS_H_ACK;
               avs_waitrequest <= !bus.wr_en;
            end
            FELS_H_WAIT: begin
               if (bus.rvalid) begin
                  state <= FELS_H_ACK;
                  avs_waitrequest <= 1'b0;
               end
            end
            FELS_H_ACK: begin
               state <= FELS_H_IDLE;
            end
         endcase
      end
   end

   // ======================================================
   // Registers
   always_ff @(posedge bus.clock or posedge bus.rst) begin
      if (bus.rst) begin
         flash_addr <= '0;
         last_rdata <= '0;
         avs_readdata <= 32'h00000000;
      end else begin
         if (state == FELS_H_IDLE && avs_write && avs_address == `FELS_REG_ADDR) begin
            flash_addr <= avs_writedata[ADDR_W-1:0];
         end
         if (bus.rvalid) begin
            last_rdata <= bus.rdata;
         end
         if (state == FELS_H_IDLE && avs_read) begin
            unique case (avs_address)
               `FELS_REG_ADDR: avs_readdata <= 32'(flash_addr);
               `FELS_REG_RDATA: avs_readdata <= 32'(last_rdata);
               default: avs_readdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

//--- verification/fels_chk.sv
// Assertions on the flash link between host and device
`include "fels_defines.svh"
`default_nettype none
module fels_chk #(
   parameter int ADDR_W = 16,
   parameter int DATA_W = 16
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic rvalid
);
   timeunit 1ns;
   timeprecision 100ps;
   logic pend;
   logic stat_mode;
   logic seq_err;
   logic [1:0] stat_part;
   logic stat_rd;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // ======
   // Command tracking
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pend <= 1'b0;
         stat_mode <= 1'b0;
         stat_part <= 2'h0;
      end else if (wr_en) begin
         pend <= !pend && wdata[7:0] == `FELS_CMD_ERASE_SETUP;
         stat_mode <= !pend && wdata[7:0] == `FELS_CMD_READ_STATUS;
         stat_part <= addr[ADDR_W-1 -: 2];
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         seq_err <= 1'b0;
      end else if (wr_en && pend && wdata[7:0] != `FELS_CMD_CONFIRM) begin
         seq_err <= 1'b1;
      end else if (wr_en && !pend && wdata[7:0] == `FELS_CMD_CLEAR_STATUS) begin
         seq_err <= 1'b0;
      end
   end
   assign stat_rd = rvalid && stat_mode && addr[ADDR_W-1 -: 2] == stat_part;
   // ======
   // Properties
   chk_read_answer: assert property (rd_en |=> rvalid)
      else $error("read without answer");
   chk_answer_cause: assert property (rvalid |-> $past(rd_en))
      else $error("answer without read");
   chk_rdata_hold: assert property (!rvalid |-> $stable(rdata))
      else $error("read data moved without answer");
   chk_status_form: assert property (stat_rd |-> rdata[2] == 1'b0 && rdata[0] == 1'b0)
      else $error("status read with unused bits set");
   chk_seq_error: assert property (stat_rd && seq_err |-> rdata[5:4] == 2'b11)
      else $error("sequence error not reported");
   chk_write_pulse: assert property (wr_en |=> !wr_en)
      else $error("write cycle longer than one clock");
   chk_one_request: assert property (wr_en |-> !rd_en)
      else $error("read and write together");
   chk_addr_quiet: assert property ($changed(addr) |-> wr_en || rd_en)
      else $error("address moved without a cycle");
endmodule
`default_nettype wire

//--- verification/tb_flash_erase_lock_otp_sequencer.sv
// Bench driving host registers and checking the flash device
`include "fels_defines.svh"
`default_nettype none
module tb_flash_erase_lock_otp_sequencer
   import fels_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int OTP_W = 16;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic program_supply_pin = 1'b1;
   logic array_fail = 1'b0;
   logic otp_locked = 1'b0;
   logic [15:0] array_rdata = 16'h5A3C;
   logic op_start;
   logic [1:0] op_kind;
   logic [15:0] op_addr;
   logic [15:0] op_data;
   logic [7:0] operation_status;
   logic [31:0] rv;
   int miscompares = 0;
   int n_checks = 0;
   int n_ops = 0;
   fels_if fl (.clock(clock), .rst(rst));
   fels_host fels_host_i (.bus(fl), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   fels_device #(.OTP_WORDS(OTP_W)) fels_device_i (.bus(fl), .program_supply_pin(program_supply_pin),
      .array_fail(array_fail), .otp_locked(otp_locked), .array_rdata(array_rdata), .op_start(op_start),
      .op_kind(op_kind), .op_addr(op_addr), .op_data(op_data), .operation_status(operation_status));
   fels_chk fels_chk_i (.clock(clock), .rst(rst), .wr_en(fl.wr_en), .rd_en(fl.rd_en), .addr(fl.addr),
      .wdata(fl.wdata), .rdata(fl.rdata), .rvalid(fl.rvalid));
   always #12.5 clock = ~clock;
   always @(posedge clock) begin
      if (op_start === 1'b1) n_ops++;
   end
   // ======
   // Shared tasks
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      rv = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         miscompares++;
         print_verdict();
      end
   endtask
   task automatic fl_wr(input logic [15:0] a, input logic [15:0] c);
      av(1'b1, `FELS_REG_ADDR, {16'h0000, a});
      av(1'b1, `FELS_REG_WDATA, {16'h0000, c});
   endtask
   task automatic fl_rd(input logic [15:0] a);
      av(1'b1, `FELS_REG_ADDR, {16'h0000, a});
      av(1'b1, `FELS_REG_READ, 32'h0);
      av(1'b0, `FELS_REG_RDATA, 32'h0);
   endtask
   task automatic cmd2(input logic [15:0] a, input logic [15:0] c1, input logic [15:0] c2);
      fl_wr(a, c1);
      fl_wr(a, c2);
   endtask
   task automatic stat(input logic [15:0] a, input logic [7:0] exp);
      fl_wr(a, 16'h0070);
      fl_rd(a);
      check(rv[7:0], exp);
   endtask
   task automatic wait_rdy(input logic [15:0] a);
      int n;
      n = 0;
      do begin
         fl_rd(a);
         n++;
      end while (rv[7] !== 1'b1 && n < 40);
      if (rv[7] !== 1'b1) begin
         miscompares++;
         print_verdict();
      end
   endtask
   // ======
   // Scenarios
   task automatic t_regs();
      check(operation_status, 8'h80);
      av(1'b1, `FELS_REG_ADDR, 32'h0000ABCD);
      av(1'b1, 4'h2, 32'h0000FFFF);
      av(1'b0, `FELS_REG_ADDR, 32'h0);
      check(rv, 32'h0000ABCD);
      av(1'b0, 4'h2, 32'h0);
      check(rv, 32'h0);
   endtask
   task automatic t_lock();
      logic [15:0] cf [4] = '{16'h00D0, 16'h0001, 16'h002F, 16'h00D0};
      logic [1:0] ex [4] = '{2'h0, 2'h1, 2'h3, 2'h3};
      int ops;
      ops = n_ops;
      cmd2(16'h1000, 16'h0020, 16'h00D0);
      wait_rdy(16'h1000);
      check(n_ops, ops);
      stat(16'h1000, 8'h82);
      fl_wr(16'h1000, 16'h0050);
      stat(16'h1000, 8'h80);
      cmd2(16'h1000, 16'h0060, 16'h00D0);
      for (int i = 0; i < 4; i++) begin
         cmd2(16'h3000, 16'h0060, cf[i]);
         fl_wr(16'h3002, 16'h0090);
         fl_rd(16'h3002);
         check(rv[1:0], ex[i]);
      end
   endtask
   task automatic t_erase();
      int ops;
      ops = n_ops;
      array_fail <= 1'b1;
      cmd2(16'h1000, 16'h0020, 16'h00D0);
      check(op_kind, FELS_OP_ERASE);
      check(op_addr, 16'h1000);
      wait_rdy(16'h1000);
      array_fail <= 1'b0;
      check(rv[7:0], 8'hA0);
      cmd2(16'h1000, 16'h0020, 16'h00D0);
      wait_rdy(16'h1000);
      check(rv[7:0], 8'hA0);
      check(n_ops, ops + 2);
      fl_wr(16'h1000, 16'h0050);
      program_supply_pin <= 1'b0;
      cmd2(16'h1000, 16'h0020, 16'h00D0);
      wait_rdy(16'h1000);
      check(rv[7:0], 8'h88);
      program_supply_pin <= 1'b1;
      fl_wr(16'h1000, 16'h0050);
      cmd2(16'h1000, 16'h0020, 16'h0070);
      stat(16'h1000, 8'hB0);
      fl_wr(16'h1000, 16'h0050);
      stat(16'h1000, 8'h80);
   endtask
   task automatic t_susp();
      cmd2(16'h2000, 16'h0060, 16'h00D0);
      cmd2(16'h1000, 16'h0020, 16'h00D0);
      cmd2(16'h1000, 16'h0070, 16'h00B0);
      fl_rd(16'h1000);
      check(rv[7:6], 2'h3);
      fl_wr(16'h2000, 16'h00FF);
      fl_rd(16'h2000);
      check(rv[15:0], 16'h5A3C);
      fl_rd(16'h1004);
      check(rv[15:0], `FELS_HIDDEN_DATA);
      stat(16'h2000, 8'hC0);
      cmd2(16'h2004, 16'h0040, 16'h1357);
      check(op_kind, FELS_OP_PROG);
      wait_rdy(16'h2000);
      check(rv[7:6], 2'h3);
      cmd2(16'h1008, 16'h0040, 16'h1357);
      stat(16'h2000, 8'hD0);
      fl_wr(16'h2000, 16'h0050);
      fl_wr(16'hC000, 16'h00D0);
      fl_rd(16'h2000);
      check(rv[7:6], 2'h0);
      wait_rdy(16'h2000);
      cmd2(16'h1000, 16'h0070, 16'h00B0);
      fl_rd(16'h1000);
      check(rv[7:6], 2'h2);
   endtask
   task automatic t_otp();
      logic [15:0] oa [5] = '{16'h0083, `FELS_OTP_BASE + 16'(OTP_W), 16'h0081, 16'h0082, 16'h0084};
      logic [7:0] ex [5] = '{8'h80, 8'h90, 8'h82, 8'h90, 8'h88};
      int ops;
      for (int i = 0; i < 5; i++) begin
         ops = n_ops;
         otp_locked <= (i == 2);
         array_fail <= (i == 3);
         program_supply_pin <= (i != 4);
         fl_wr(16'h0080, 16'h00C0);
         fl_wr(oa[i], 16'h1234);
         if (i == 0) begin
            check(op_kind, FELS_OP_OTP);
            check({op_addr, op_data}, {16'h0083, 16'h1234});
         end
         if (i == 1) begin
            check(n_ops, ops);
         end
         wait_rdy(16'h0080);
         check(rv[7:0], ex[i]);
         fl_wr(16'h0080, 16'h0050);
      end
      otp_locked <= 1'b0;
      array_fail <= 1'b0;
      program_supply_pin <= 1'b1;
   endtask
   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      t_regs();
      t_lock();
      t_erase();
      t_susp();
      t_otp();
      print_verdict();
   end
endmodule
`default_nettype wire
